// ---- core/cie_pkg.sv ----
// Package for the instruction execute subset: opcodes, flags, reset values
package cie_pkg;

    localparam int DATA_W = 8;
    localparam int ADDR_W = 7;

    // Direction register selectors
    localparam logic [6:0] DIR_SEL_A = 7'h05;
    localparam logic [6:0] DIR_SEL_B = 7'h06;
    localparam logic [6:0] DIR_SEL_C = 7'h07;

    // Reset values
    localparam logic [7:0] ACC_RST = 8'h00;
    localparam logic [7:0] DIR_RST = 8'hff;
    localparam logic [7:0] WDT_CLEAR = 8'h00;
    localparam logic [7:0] PRESCALE_CLEAR = 8'h00;

    // Destination bit values
    localparam logic DEST_ACC = 1'b0;
    localparam logic DEST_FILE = 1'b1;

    typedef enum logic [3:0] {
        CIE_OP_NONE,
        CIE_OP_ROTATE_RIGHT_THROUGH_CARRY,
        CIE_OP_LITERAL_MINUS_ACCUMULATOR,
        CIE_OP_FILE_MINUS_ACCUMULATOR,
        CIE_OP_FILE_MINUS_ACCUMULATOR_BORROW,
        CIE_OP_NIBBLE_EXCHANGE,
        CIE_OP_DIRECTION_LOAD,
        CIE_OP_EXCLUSIVE_OR_LITERAL,
        CIE_OP_EXCLUSIVE_OR_FILE,
        CIE_OP_SLEEP
    } cie_op_type;

    // One decoded instruction
    typedef struct packed {
        cie_op_type op;
        logic [6:0] file_addr;
        logic dest;
        logic [7:0] literal;
    } cie_instr_type;

    // Arithmetic status flags
    typedef struct packed {
        logic zero;
        logic nibble_carry_flag;
        logic carry;
    } cie_flags_type;

    // File register write request
    typedef struct packed {
        logic en;
        logic [6:0] addr;
        logic [7:0] data;
    } cie_fwrite_type;

endpackage

// ---- core/cie_execute.sv ----
// Execute stage for the rotate, subtract, swap, xor, direction-load and sleep instructions
//----------------------------------------------------------------------
//----------------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none

module cie_execute
(
    input wire logic i_ref_clk, // Core clock, 200 MHz
    input wire logic i_resetn, // Synchronous reset, active low
    input wire logic i_valid, // Instruction present this cycle
    input wire cie_pkg::cie_instr_type i_instr, // Decoded instruction
    input wire logic [7:0] i_file_rdata, // Addressed file register contents
    input wire logic i_wake, // Wake-up condition
    output logic [7:0] o_accumulator, // Working register
    output cie_pkg::cie_flags_type o_flags, // Carry, nibble carry, zero
    output cie_pkg::cie_fwrite_type o_file_write, // File register write pulse
    output logic [7:0] o_port_a_direction, // Port A direction register
    output logic [7:0] o_port_b_direction, // Port B direction register
    output logic [7:0] o_port_c_direction, // Port C direction register
    output logic [7:0] o_watchdog_counter, // Watchdog count
    output logic [7:0] o_watchdog_prescaler, // Watchdog prescaler count
    output logic o_watchdog_expiry_flag, // Expiry status, high when not expired
    output logic o_power_down_flag, // Power-down status
    output logic o_sleeping, // Execution halted
    output logic o_osc_stop // Oscillator stop request
);

    //------------------------------------------------------------------
    // Arithmetic helpers
    //------------------------------------------------------------------
    // a - b - !nb where nb is the not-borrow carry, returns {carry, nibble carry, result}
    function automatic logic [9:0] sub_op(input logic [7:0] a, input logic [7:0] b, input logic nb);
        logic [8:0] full;
        logic [4:0] low;
        full = {1'b0, a} + {1'b0, ~b} + {8'h00, nb};
        low = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + {4'h0, nb};
        sub_op = {full[8], low[4], full[7:0]};
    endfunction

    function automatic logic is_zero(input logic [7:0] r);
        is_zero = (r == 8'h00);
    endfunction

    //------------------------------------------------------------------
    // Result and flag computation
    //------------------------------------------------------------------
    logic [7:0] acc_q;
    logic [7:0] acc_d;
    cie_pkg::cie_flags_type flags_q;
    cie_pkg::cie_flags_type flags_d;
    logic [7:0] result;
    logic has_result;
    logic [9:0] sub_res;
    logic sleeping_q;
    logic go;

    assign go = i_valid && !sleeping_q;

    always_comb
    begin
        result = 8'h00;
        has_result = 1'b0;
        flags_d = flags_q;
        sub_res = 10'h000;
        unique case (i_instr.op)
            cie_pkg::CIE_OP_ROTATE_RIGHT_THROUGH_CARRY:
            begin
                result = {flags_q.carry, i_file_rdata[7:1]};
                flags_d.carry = i_file_rdata[0];
                has_result = 1'b1;
            end
            cie_pkg::CIE_OP_LITERAL_MINUS_ACCUMULATOR:
            begin
                sub_res = sub_op(i_instr.literal, acc_q, 1'b1);
                result = sub_res[7:0];
                flags_d.carry = sub_res[9];
                flags_d.nibble_carry_flag = sub_res[8];
                flags_d.zero = is_zero(result);
                has_result = 1'b1;
            end
            cie_pkg::CIE_OP_FILE_MINUS_ACCUMULATOR:
            begin
                sub_res = sub_op(i_file_rdata, acc_q, 1'b1);
                result = sub_res[7:0];
                flags_d.carry = sub_res[9];
                flags_d.nibble_carry_flag = sub_res[8];
                flags_d.zero = is_zero(result);
                has_result = 1'b1;
            end
            cie_pkg::CIE_OP_FILE_MINUS_ACCUMULATOR_BORROW:
            begin
                sub_res = sub_op(i_file_rdata, acc_q, flags_q.carry);
                result = sub_res[7:0];
                flags_d.carry = sub_res[9];
                flags_d.nibble_carry_flag = sub_res[8];
                flags_d.zero = is_zero(result);
                has_result = 1'b1;
            end
            cie_pkg::CIE_OP_NIBBLE_EXCHANGE:
            begin
                result = {i_file_rdata[3:0], i_file_rdata[7:4]};
                has_result = 1'b1;
            end
            cie_pkg::CIE_OP_EXCLUSIVE_OR_LITERAL:
            begin
                result = acc_q ^ i_instr.literal;
                flags_d.zero = is_zero(result);
                has_result = 1'b1;
            end
            cie_pkg::CIE_OP_EXCLUSIVE_OR_FILE:
            begin
                result = acc_q ^ i_file_rdata;
                flags_d.zero = is_zero(result);
                has_result = 1'b1;
            end
            default:
            begin
                result = 8'h00;
            end
        endcase
    end

    // Literal-only ops always land in the accumulator
    logic lit_op;
    logic to_file;
    assign lit_op = (i_instr.op == cie_pkg::CIE_OP_LITERAL_MINUS_ACCUMULATOR)
                 || (i_instr.op == cie_pkg::CIE_OP_EXCLUSIVE_OR_LITERAL);
    assign to_file = has_result && !lit_op && (i_instr.dest == cie_pkg::DEST_FILE);

    always_comb
    begin
        acc_d = acc_q;
        if (go && has_result && !to_file)
        begin
            acc_d = result;
        end
    end

    //------------------------------------------------------------------
    // Accumulator and flags
    //------------------------------------------------------------------
    always_ff @(posedge i_ref_clk)
    begin
        if (!i_resetn)
        begin
            acc_q <= cie_pkg::ACC_RST;
        end
        else
        begin
            acc_q <= acc_d;
        end
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (!i_resetn)
        begin
            flags_q <= '0;
        end
        else if (go)
        begin
            flags_q <= flags_d;
        end
    end

    //------------------------------------------------------------------
    // File register write
    //------------------------------------------------------------------
    cie_pkg::cie_fwrite_type fw_q;

    always_ff @(posedge i_ref_clk)
    begin
        if (!i_resetn)
        begin
            fw_q <= '0;
        end
        else
        begin
            fw_q.en <= go && to_file;
            fw_q.addr <= i_instr.file_addr;
            fw_q.data <= result;
        end
    end

    //------------------------------------------------------------------
    // Direction registers
    //------------------------------------------------------------------
    logic [7:0] dir_a_q;
    logic [7:0] dir_b_q;
    logic [7:0] dir_c_q;
    logic dir_go;
    assign dir_go = go && (i_instr.op == cie_pkg::CIE_OP_DIRECTION_LOAD);

    always_ff @(posedge i_ref_clk)
    begin
        if (!i_resetn)
        begin
            dir_a_q <= cie_pkg::DIR_RST;
            dir_b_q <= cie_pkg::DIR_RST;
            dir_c_q <= cie_pkg::DIR_RST;
        end
        else if (dir_go)
        begin
            if (i_instr.file_addr == cie_pkg::DIR_SEL_A) dir_a_q <= acc_q;
            if (i_instr.file_addr == cie_pkg::DIR_SEL_B) dir_b_q <= acc_q;
            if (i_instr.file_addr == cie_pkg::DIR_SEL_C) dir_c_q <= acc_q;
        end
    end

    //------------------------------------------------------------------
    // Sleep, watchdog and power status
    //------------------------------------------------------------------
    logic [7:0] wdt_q;
    logic [7:0] pre_q;
    logic expiry_q;
    logic pd_q;
    logic sleep_go;
    assign sleep_go = go && (i_instr.op == cie_pkg::CIE_OP_SLEEP);

    // Free-running watchdog; sleep clears count and prescaler
    always_ff @(posedge i_ref_clk)
    begin
        if (!i_resetn || sleep_go)
        begin
            wdt_q <= cie_pkg::WDT_CLEAR;
            pre_q <= cie_pkg::PRESCALE_CLEAR;
        end
        else
        begin
            pre_q <= pre_q + 8'h01;
            if (pre_q == 8'hff)
            begin
                wdt_q <= wdt_q + 8'h01;
            end
        end
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (!i_resetn)
        begin
            expiry_q <= 1'b1;
            pd_q <= 1'b1;
        end
        else if (sleep_go)
        begin
            expiry_q <= 1'b1;
            pd_q <= 1'b0;
        end
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (!i_resetn)
        begin
            sleeping_q <= 1'b0;
        end
        else if (sleep_go)
        begin
            sleeping_q <= 1'b1;
        end
        else if (i_wake)
        begin
            sleeping_q <= 1'b0;
        end
    end

    //------------------------------------------------------------------
    // Outputs
    //------------------------------------------------------------------
    assign o_accumulator = acc_q;
    assign o_flags = flags_q;
    assign o_file_write = fw_q;
    assign o_port_a_direction = dir_a_q;
    assign o_port_b_direction = dir_b_q;
    assign o_port_c_direction = dir_c_q;
    assign o_watchdog_counter = wdt_q;
    assign o_watchdog_prescaler = pre_q;
    assign o_watchdog_expiry_flag = expiry_q;
    assign o_power_down_flag = pd_q;
    assign o_sleeping = sleeping_q;
    assign o_osc_stop = sleeping_q;

    //------------------------------------------------------------------
    // Assertions
    //------------------------------------------------------------------
    property p_rotate;
        @(posedge i_ref_clk) disable iff (!i_resetn)
        go && i_instr.op == cie_pkg::CIE_OP_ROTATE_RIGHT_THROUGH_CARRY
        |=> o_flags.carry == $past(i_file_rdata[0]) && o_flags.zero == $past(flags_q.zero);
    endproperty
    a_rotate: assert property (p_rotate) else $error("rotate carry wrong");

    property p_dest;
        @(posedge i_ref_clk) disable iff (!i_resetn)
        go && has_result && !lit_op && i_instr.dest == cie_pkg::DEST_FILE
        |=> o_file_write.en && o_accumulator == $past(acc_q);
    endproperty
    a_dest: assert property (p_dest) else $error("file destination wrong");

    property p_lit_sub;
        @(posedge i_ref_clk) disable iff (!i_resetn)
        go && i_instr.op == cie_pkg::CIE_OP_LITERAL_MINUS_ACCUMULATOR
        |=> o_accumulator == 8'($past(i_instr.literal) - $past(acc_q))
            && o_flags.carry == ($past(acc_q) <= $past(i_instr.literal));
    endproperty
    a_lit_sub: assert property (p_lit_sub) else $error("literal subtract wrong");

    property p_file_sub;
        @(posedge i_ref_clk) disable iff (!i_resetn)
        go && i_instr.op == cie_pkg::CIE_OP_FILE_MINUS_ACCUMULATOR
        |=> o_flags.nibble_carry_flag == ($past(acc_q[3:0]) <= $past(i_file_rdata[3:0]));
    endproperty
    a_file_sub: assert property (p_file_sub) else $error("nibble carry wrong");

    property p_swap;
        @(posedge i_ref_clk) disable iff (!i_resetn)
        go && i_instr.op == cie_pkg::CIE_OP_NIBBLE_EXCHANGE
        |=> o_flags == $past(flags_q);
    endproperty
    a_swap: assert property (p_swap) else $error("swap changed flags");

    property p_dir;
        @(posedge i_ref_clk) disable iff (!i_resetn)
        dir_go && i_instr.file_addr == cie_pkg::DIR_SEL_B |=> o_port_b_direction == $past(acc_q);
    endproperty
    a_dir: assert property (p_dir) else $error("direction load wrong");

    property p_sleep;
        @(posedge i_ref_clk) disable iff (!i_resetn)
        sleep_go |=> o_watchdog_counter == 8'h00 && o_watchdog_expiry_flag && !o_power_down_flag && o_sleeping;
    endproperty
    a_sleep: assert property (p_sleep) else $error("sleep effects wrong");

    property p_halt;
        @(posedge i_ref_clk) disable iff (!i_resetn)
        sleeping_q && !i_wake |=> $stable(o_accumulator) && !o_file_write.en;
    endproperty
    a_halt: assert property (p_halt) else $error("executed while asleep");

    property p_zero;
        @(posedge i_ref_clk) disable iff (!i_resetn)
        go && i_instr.op == cie_pkg::CIE_OP_EXCLUSIVE_OR_LITERAL
        |=> o_flags.zero == ((acc_q) == 8'h00) && o_flags.carry == $past(flags_q.carry);
    endproperty
    a_zero: assert property (p_zero) else $error("zero flag wrong");

endmodule

`default_nettype wire

// ---- verification/cie_execute_tb.sv ----
// Self-checking testbench for the instruction execute subset
`timescale 1ns/1ps
`default_nettype none

module cie_execute_tb;

    typedef struct packed {
        cie_pkg::cie_op_type op;
        logic [6:0] addr;
        logic dest;
        logic [7:0] lit;
        logic [7:0] rdata;
        logic [7:0] res;
        logic [2:0] flg;
    } cie_row_type;

    localparam cie_pkg::cie_op_type RR = cie_pkg::CIE_OP_ROTATE_RIGHT_THROUGH_CARRY;
    localparam cie_pkg::cie_op_type SL = cie_pkg::CIE_OP_LITERAL_MINUS_ACCUMULATOR;
    localparam cie_pkg::cie_op_type SF = cie_pkg::CIE_OP_FILE_MINUS_ACCUMULATOR;
    localparam cie_pkg::cie_op_type SB = cie_pkg::CIE_OP_FILE_MINUS_ACCUMULATOR_BORROW;
    localparam cie_pkg::cie_op_type SW = cie_pkg::CIE_OP_NIBBLE_EXCHANGE;
    localparam cie_pkg::cie_op_type DL = cie_pkg::CIE_OP_DIRECTION_LOAD;
    localparam cie_pkg::cie_op_type XL = cie_pkg::CIE_OP_EXCLUSIVE_OR_LITERAL;
    localparam cie_pkg::cie_op_type XF = cie_pkg::CIE_OP_EXCLUSIVE_OR_FILE;

    logic i_ref_clk = 1'b0;
    logic i_resetn = 1'b0;
    logic i_valid = 1'b0;
    cie_pkg::cie_instr_type i_instr = '0;
    logic [7:0] i_file_rdata = 8'h00;
    logic i_wake = 1'b0;
    logic [7:0] o_accumulator;
    cie_pkg::cie_flags_type o_flags;
    cie_pkg::cie_fwrite_type o_file_write;
    logic [7:0] o_port_a_direction;
    logic [7:0] o_port_b_direction;
    logic [7:0] o_port_c_direction;
    logic [7:0] o_watchdog_counter;
    logic [7:0] o_watchdog_prescaler;
    logic o_watchdog_expiry_flag;
    logic o_power_down_flag;
    logic o_sleeping;
    logic o_osc_stop;

    int err_count = 0;
    int n_tests = 0;
    cie_row_type rows [15];
    logic [7:0] acc_exp;
    logic [7:0] dir_exp [3];
    logic to_file;
    int k;

    cie_execute i_dut (
        .i_ref_clk(i_ref_clk),
        .i_resetn(i_resetn),
        .i_valid(i_valid),
        .i_instr(i_instr),
        .i_file_rdata(i_file_rdata),
        .i_wake(i_wake),
        .o_accumulator(o_accumulator),
        .o_flags(o_flags),
        .o_file_write(o_file_write),
        .o_port_a_direction(o_port_a_direction),
        .o_port_b_direction(o_port_b_direction),
        .o_port_c_direction(o_port_c_direction),
        .o_watchdog_counter(o_watchdog_counter),
        .o_watchdog_prescaler(o_watchdog_prescaler),
        .o_watchdog_expiry_flag(o_watchdog_expiry_flag),
        .o_power_down_flag(o_power_down_flag),
        .o_sleeping(o_sleeping),
        .o_osc_stop(o_osc_stop)
    );

    always #2.5 i_ref_clk = ~i_ref_clk;

    //------------------------------------------------------------
    // Tasks
    //------------------------------------------------------------
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            err_count++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic stop_test();
        $display("tests %0d errors %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // Drive one instruction, return one edge later
    task automatic exec(input cie_pkg::cie_op_type op, input logic [6:0] addr, input logic dest,
                        input logic [7:0] lit, input logic [7:0] rdata);
        i_valid = 1'b1;
        i_instr = '{op, addr, dest, lit};
        i_file_rdata = rdata;
        @(negedge i_ref_clk);
    endtask

    task automatic idle(input int n);
        i_valid = 1'b0;
        repeat (n) @(negedge i_ref_clk);
    endtask

    task automatic check_dirs();
        check("port a direction", o_port_a_direction, dir_exp[0]);
        check("port b direction", o_port_b_direction, dir_exp[1]);
        check("port c direction", o_port_c_direction, dir_exp[2]);
        check("flags", {5'h00, o_flags}, {5'h00, acc_exp == 8'h00, 2'b10});
    endtask

    task automatic do_reset();
        i_resetn = 1'b0;
        idle(6);
        check("accumulator", o_accumulator, 8'h00);
        check("flags", {5'h00, o_flags}, 8'h00);
        check("write enable", {7'h00, o_file_write.en}, 8'h00);
        check("port a direction", o_port_a_direction, 8'hff);
        check("port b direction", o_port_b_direction, 8'hff);
        check("port c direction", o_port_c_direction, 8'hff);
        check("watchdog", o_watchdog_counter, 8'h00);
        check("expiry", {7'h00, o_watchdog_expiry_flag}, 8'h01);
        check("power down", {7'h00, o_power_down_flag}, 8'h01);
        check("sleeping", {6'h00, o_sleeping, o_osc_stop}, 8'h00);
        i_resetn = 1'b1;
        acc_exp = 8'h00;
        dir_exp = '{8'hff, 8'hff, 8'hff};
    endtask

    //------------------------------------------------------------
    // Main sequence
    //------------------------------------------------------------
    initial
    begin
        rows = '{
            '{XL, 7'h00, 1'b0, 8'h5a, 8'h00, 8'h5a, 3'h0},
            '{SL, 7'h00, 1'b0, 8'h5a, 8'h00, 8'h00, 3'h7},
            '{XL, 7'h00, 1'b0, 8'ha5, 8'h00, 8'ha5, 3'h3},
            '{SF, 7'h10, 1'b1, 8'h00, 8'h30, 8'h8b, 3'h0},
            '{SB, 7'h11, 1'b0, 8'h00, 8'hb0, 8'h0a, 3'h1},
            '{SB, 7'h12, 1'b1, 8'h00, 8'h0a, 8'h00, 3'h7},
            '{RR, 7'h13, 1'b0, 8'h00, 8'h80, 8'hc0, 3'h6},
            '{RR, 7'h14, 1'b1, 8'h00, 8'h01, 8'h00, 3'h7},
            '{SW, 7'h15, 1'b0, 8'h00, 8'h3c, 8'hc3, 3'h7},
            '{SW, 7'h7f, 1'b1, 8'h00, 8'hf0, 8'h0f, 3'h7},
            '{XF, 7'h17, 1'b0, 8'h00, 8'hc3, 8'h00, 3'h7},
            '{XF, 7'h18, 1'b1, 8'h00, 8'hff, 8'hff, 3'h3},
            '{XL, 7'h00, 1'b0, 8'h22, 8'h00, 8'h22, 3'h3},
            '{SL, 7'h00, 1'b0, 8'h13, 8'h00, 8'hf1, 3'h2},
            '{XL, 7'h00, 1'b0, 8'hf1, 8'h00, 8'h00, 3'h6}
        };
        @(negedge i_ref_clk);
        do_reset();
        // Back-to-back table rows
        for (int i = 0; i < 15; i++)
        begin
            exec(rows[i].op, rows[i].addr, rows[i].dest, rows[i].lit, rows[i].rdata);
            to_file = rows[i].dest && rows[i].op != XL && rows[i].op != SL;
            if (!to_file)
                acc_exp = rows[i].res;
            check("accumulator", o_accumulator, acc_exp);
            check("flags", {5'h00, o_flags}, {5'h00, rows[i].flg});
            check("write enable", {7'h00, o_file_write.en}, {7'h00, to_file});
            if (to_file)
            begin
                check("write addr", {1'b0, o_file_write.addr}, {1'b0, rows[i].addr});
                check("write data", o_file_write.data, rows[i].res);
            end
        end
        // Direction loads for each port, then an unmapped selector
        for (int i = 0; i < 4; i++)
        begin
            acc_exp = acc_exp ^ (i < 3 ? 8'(8'h0f << i) : 8'hff);
            exec(XL, 7'h00, 1'b0, i < 3 ? 8'(8'h0f << i) : 8'hff, 8'h00);
            exec(DL, i < 3 ? 7'(5 + i) : 7'h04, 1'b0, 8'h00, 8'h00);
            if (i < 3)
                dir_exp[i] = acc_exp;
            check_dirs();
        end
        // Not valid, then the empty op
        i_instr = '{XL, 7'h00, 1'b0, 8'h55};
        idle(2);
        exec(cie_pkg::CIE_OP_NONE, 7'h00, 1'b1, 8'h55, 8'h55);
        check("accumulator", o_accumulator, acc_exp);
        check("write enable", {7'h00, o_file_write.en}, 8'h00);
        // Sleep after the watchdog has advanced
        idle(300);
        exec(cie_pkg::CIE_OP_SLEEP, 7'h00, 1'b0, 8'h00, 8'h00);
        check("watchdog", o_watchdog_counter, 8'h00);
        check("prescaler", o_watchdog_prescaler, 8'h00);
        check("expiry", {7'h00, o_watchdog_expiry_flag}, 8'h01);
        check("power down", {7'h00, o_power_down_flag}, 8'h00);
        check("sleeping", {6'h00, o_sleeping, o_osc_stop}, 8'h03);
        exec(XL, 7'h00, 1'b0, 8'h55, 8'h00);
        check("accumulator", o_accumulator, acc_exp);
        idle(1);
        i_wake = 1'b1;
        k = 0;
        while (o_sleeping !== 1'b0 && k < 4)
        begin
            @(negedge i_ref_clk);
            k++;
        end
        if (k >= 4)
        begin
            err_count++;
            stop_test();
        end
        i_wake = 1'b0;
        check("osc stop", {7'h00, o_osc_stop}, 8'h00);
        acc_exp = acc_exp ^ 8'h55;
        exec(XL, 7'h00, 1'b0, 8'h55, 8'h00);
        check("accumulator", o_accumulator, acc_exp);
        // Reset again in mid-run
        do_reset();
        stop_test();
    end

endmodule

`default_nettype wire
